/* hdl/acp_pin_ctrl.sv */
// Notes on behaviour
// - chip select tied low gives 3-wire mode
// - respond on serial bus only while selected
// - chip select frames and realigns each byte
// - reset pin restores logic and registers, except the master clock output enable
// - clock keeps running through reset
// - master clock out inverted or switched off
// - pin zero direction and data via port
// - pin one direction and data via port
// - sync bit makes pin one align input
// - ready falls on unread data or calibration
// - data goes to register the command selects
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"
module acp_pin_ctrl
  import acp_pkg::*;
(
  // master clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // serial port
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       din_in,
  output logic            dout_out,
  output logic            dout_oe_out,
  // device reset pin and reset to converter core
  input  wire logic       reset_n_in,
  output logic            device_reset_out,
  // master clock output
  input  wire logic       mclk_enable_in,
  output logic            master_clock_out,
  // general pins
  input  wire logic       general_pin_zero_in,
  output logic            general_pin_zero_out,
  output logic            general_pin_zero_oe_out,
  input  wire logic       general_pin_one_in,
  output logic            general_pin_one_out,
  output logic            general_pin_one_oe_out,
  // converter status and control
  input  wire logic [1:0] channel_unread_in,
  input  wire logic       cal_mode_in,
  input  wire logic       cal_done_in,
  output logic            ready_n_out,
  output logic            align_or_pin_one_out,
  output acp_port_s       port_reg_out
);

  // ==================================================================
  // serial clock domain
  acp_link_s  link_q;       // registered link state
  acp_link_s  link_d;       // next link state
  logic [2:0] cnt_q;        // bit position within the byte
  logic       cnt_clr;      // frame end or device reset
  logic [7:0] rx_byte;      // byte completed on this edge
  logic       byte_done;    // last bit of a byte arrives
  logic       dout_q;       // serial output bit
  acp_core_s  core_q;       // registered core state
  acp_core_s  core_d;       // next core state

  // a deselect ends the frame even with the serial clock stopped
  // phase survives a deselect, so a select tied low still frames bytes
  assign cnt_clr   = cs_n_in | core_q.dev_rst;
  assign rx_byte   = {link_q.shift[6:0], din_in};
  assign byte_done = (cnt_q == `ACP_BIT_LAST);

  // bit counter, realigned by every deselect
  always_ff @(posedge sclk_in or posedge cnt_clr) begin
    if (cnt_clr) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // command decode and byte assembly
  always_comb begin
    link_d        = link_q;
    // image words change rarely; two stages on the serial clock settle them
    link_d.img_s1 = core_q.img;
    link_d.img_s2 = link_q.img_s1;
    link_d.shift  = rx_byte;
    if (byte_done) begin
      if (link_q.phase == ACP_COMM) begin
        // a set top bit is not a command; stay waiting
        if (!rx_byte[`ACP_COMM_WEN_BIT]) begin
          link_d.phase = ACP_DATA;
          link_d.rd    = rx_byte[`ACP_COMM_RD_BIT];
          link_d.addr  = rx_byte[5:0];
          // unmapped registers read back as zero
          if (rx_byte[5:0] == `ACP_ADDR_PORT) begin
            link_d.tx = link_q.img_s2;
          end else begin
            link_d.tx = 8'h00;
          end
        end
      end else begin
        link_d.phase = ACP_COMM;
        if (!link_q.rd) begin
          link_d.wr_tgl  = ~link_q.wr_tgl;
          link_d.wr_addr = link_q.addr;
          link_d.wr_data = rx_byte;
        end
      end
    end
  end

  // link state, shifted only while selected
  always_ff @(posedge sclk_in or posedge core_q.dev_rst) begin
    if (core_q.dev_rst) begin
      link_q <= '0;
    end else if (!cs_n_in) begin
      link_q <= link_d;
    end
  end

  // output bits change on the falling edge, msb first
  always_ff @(negedge sclk_in or posedge core_q.dev_rst) begin
    if (core_q.dev_rst) begin
      dout_q <= 1'b0;
    end else if (link_q.phase == ACP_DATA && link_q.rd) begin
      dout_q <= link_q.tx[~cnt_q];
    end else begin
      dout_q <= 1'b0;
    end
  end

  // ==================================================================
  // master clock domain
  always_comb begin
    core_d        = core_q;
    // two-stage synchronisers on chip select, reset pin and both general pins
    core_d.cs_s1  = cs_n_in;
    core_d.cs_s2  = core_q.cs_s1;
    core_d.rst_s1 = reset_n_in;
    core_d.rst_s2 = core_q.rst_s1;
    core_d.p0_s1  = general_pin_zero_in;
    core_d.p0_s2  = core_q.p0_s1;
    core_d.p1_s1  = general_pin_one_in;
    core_d.p1_s2  = core_q.p1_s1;
    core_d.wr_s1  = link_q.wr_tgl;
    core_d.wr_s2  = core_q.wr_s1;
    core_d.wr_s3  = core_q.wr_s2;
    core_d.dev_rst = ~core_q.rst_s2;
    // the oscillator side is never touched by the reset pin
    core_d.mclk_en = mclk_enable_in;
    // held write data is stable by the time the toggle arrives
    if (core_q.dev_rst) begin
      core_d.port = acp_port_s'(`ACP_PORT_RESET);
    end else if (core_q.wr_s2 != core_q.wr_s3 &&
                 link_q.wr_addr == `ACP_ADDR_PORT) begin
      core_d.port      = acp_port_s'(link_q.wr_data);
      core_d.port.zero = 2'h0;
    end
    // read image shows the pin levels in bits 7 and 6, not the written data
    core_d.img    = core_q.port;
    core_d.img[7] = core_q.p0_s2;
    core_d.img[6] = core_q.p1_s2;
    // pin drivers: direction bit 1 means input
    core_d.p0_o   = core_q.port.p0;
    core_d.p0_oe  = ~core_q.port.pin_zero_direction & ~core_q.dev_rst;
    core_d.p1_o   = core_q.port.p1;
    core_d.p1_oe  = ~core_q.port.pin_one_direction & ~core_q.port.sync &
                    ~core_q.dev_rst;
    // align request while the sync input is held low
    core_d.align  = core_q.port.sync & ~core_q.p1_s2;
    // drive the shared serial line only while selected
    core_d.dout_oe = ~core_q.cs_s2 & ~core_q.dev_rst;
    // ready: calibration done, else unread data per function bit
    if (core_q.dev_rst) begin
      core_d.ready_n = 1'b1;
    end else if (cal_mode_in) begin
      core_d.ready_n = ~cal_done_in;
    end else if (core_q.port.ready_fn) begin
      core_d.ready_n = ~(&channel_unread_in);
    end else begin
      core_d.ready_n = ~(|channel_unread_in);
    end
  end

  // core state; reset pin stages idle high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core_q         <= '0;
      core_q.rst_s1  <= 1'b1;
      core_q.rst_s2  <= 1'b1;
      core_q.cs_s1   <= 1'b1;
      core_q.cs_s2   <= 1'b1;
      core_q.dev_rst <= 1'b1;
      core_q.ready_n <= 1'b1;
      core_q.port    <= acp_port_s'(`ACP_PORT_RESET);
    end else begin
      core_q <= core_d;
    end
  end

  // ==================================================================
  // outputs
  // the inverted clock cannot come from a flop at full rate
  assign master_clock_out        = core_q.mclk_en & ~clk_in;
  assign dout_out                = dout_q;
  assign dout_oe_out             = core_q.dout_oe;
  assign device_reset_out        = core_q.dev_rst;
  assign general_pin_zero_out    = core_q.p0_o;
  assign general_pin_zero_oe_out = core_q.p0_oe;
  assign general_pin_one_out     = core_q.p1_o;
  assign general_pin_one_oe_out  = core_q.p1_oe;
  assign ready_n_out             = core_q.ready_n;
  assign align_or_pin_one_out    = core_q.align;
  assign port_reg_out            = core_q.port;

  // ==================================================================
  // assertions
  property p_dout_off;
    @(posedge clk_in) disable iff (rst_in)
    cs_n_in [*3] |=> !dout_oe_out;
  endproperty
  a_dout_off: assert property (p_dout_off)
    else $error("serial output driven while deselected");

  property p_dout_on;
    @(posedge clk_in) disable iff (rst_in)
    (!cs_n_in && reset_n_in) [*5] |=> dout_oe_out;
  endproperty
  a_dout_on: assert property (p_dout_on)
    else $error("serial output idle while selected");

  property p_reset_port;
    @(posedge clk_in) disable iff (rst_in)
    core_q.dev_rst |=> core_q.port == acp_port_s'(`ACP_PORT_RESET);
  endproperty
  a_reset_port: assert property (p_reset_port)
    else $error("port register not at reset value");

  property p_mclk_keep;
    @(posedge clk_in) disable iff (rst_in)
    core_q.dev_rst |=> core_q.mclk_en == $past(mclk_enable_in);
  endproperty
  a_mclk_keep: assert property (p_mclk_keep)
    else $error("clock output control disturbed by reset");

  property p_mclk_on;
    @(posedge clk_in) disable iff (rst_in)
    core_q.mclk_en |-> master_clock_out;
  endproperty
  a_mclk_on: assert property (p_mclk_on)
    else $error("clock output not inverted master clock");

  property p_pin_zero_direction;
    @(posedge clk_in) disable iff (rst_in)
    (!core_q.dev_rst && !core_q.port.pin_zero_direction) |=>
      general_pin_zero_oe_out &&
      general_pin_zero_out == $past(core_q.port.p0);
  endproperty
  a_pin_zero_direction: assert property (p_pin_zero_direction)
    else $error("pin zero not driven as output");

  property p_p1_in;
    @(posedge clk_in) disable iff (rst_in)
    (core_q.port.pin_one_direction || core_q.port.sync) |=>
      !general_pin_one_oe_out;
  endproperty
  a_p1_in: assert property (p_p1_in)
    else $error("pin one driven while input");

  property p_align;
    @(posedge clk_in) disable iff (rst_in)
    (core_q.port.sync && !general_pin_one_in) [*3] |=>
      align_or_pin_one_out;
  endproperty
  a_align: assert property (p_align)
    else $error("align request missing");

  property p_ready_all;
    @(posedge clk_in) disable iff (rst_in)
    (!core_q.dev_rst && !cal_mode_in && core_q.port.ready_fn &&
     channel_unread_in == 2'h1) |=> ready_n_out;
  endproperty
  a_ready_all: assert property (p_ready_all)
    else $error("ready fell with only one channel unread");

  property p_ready_any;
    @(posedge clk_in) disable iff (rst_in)
    (!core_q.dev_rst && !cal_mode_in && !core_q.port.ready_fn &&
     (|channel_unread_in)) |=> !ready_n_out;
  endproperty
  a_ready_any: assert property (p_ready_any)
    else $error("ready stayed high with unread data");

  property p_write;
    @(posedge clk_in) disable iff (rst_in)
    (!core_q.dev_rst && core_q.wr_s2 != core_q.wr_s3 &&
     link_q.wr_addr == `ACP_ADDR_PORT) |=>
      core_q.port.pin_zero_direction == $past(link_q.wr_data[5]);
  endproperty
  a_write: assert property (p_write)
    else $error("port write not applied");

  property p_frame;
    @(posedge sclk_in) disable iff (core_q.dev_rst || cs_n_in)
    (byte_done && link_q.phase == ACP_COMM &&
     !rx_byte[`ACP_COMM_WEN_BIT]) |=> link_q.phase == ACP_DATA;
  endproperty
  a_frame: assert property (p_frame)
    else $error("command byte not followed by data phase");

  c_write: cover property (@(posedge clk_in) disable iff (rst_in)
    core_q.wr_s2 != core_q.wr_s3);
  c_read: cover property (@(posedge sclk_in)
    link_q.phase == ACP_DATA && link_q.rd);
  c_align: cover property (@(posedge clk_in) disable iff (rst_in)
    align_or_pin_one_out);

endmodule
`default_nettype wire

/* hdl/acp_regs.svh */
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH
// ====================================================================
// register addresses carried in the communications byte
`define ACP_ADDR_COMM   6'h00
`define ACP_ADDR_PORT   6'h01
// ====================================================================
// communications byte fields
`define ACP_COMM_WEN_BIT  7
`define ACP_COMM_RD_BIT   6
// ====================================================================
// port register reset value: both pins inputs, all else clear
`define ACP_PORT_RESET  8'h30
// ====================================================================
// serial framing: index of the last bit of a byte
`define ACP_BIT_LAST    3'h7
`endif

/* hdl/acp_pkg.sv */
`include "acp_regs.svh"
package acp_pkg;
  // port register layout, msb first
  typedef struct packed {
    logic       p0;         // general pin zero level
    logic       p1;         // general pin one level
    logic       pin_zero_direction;     // 1 = pin zero is an input
    logic       pin_one_direction;     // 1 = pin one is an input
    logic       ready_fn;   // 0 = any channel, 1 = all channels
    logic [1:0] zero;       // reads as zero
    logic       sync;       // pin one is the align input
  } acp_port_s;

  // serial transaction phase
  typedef enum logic {ACP_COMM, ACP_DATA} acp_phase_e;

  // state of the logic on the serial clock
  typedef struct packed {
    logic [7:0] shift;      // bits received so far
    acp_phase_e phase;      // expecting command or data byte
    logic       rd;         // current transaction is a read
    logic [5:0] addr;       // register selected by the command
    logic [7:0] tx;         // byte being shifted out
    logic       wr_tgl;     // toggles once per completed write
    logic [5:0] wr_addr;    // held address of the last write
    logic [7:0] wr_data;    // held data of the last write
    logic [7:0] img_s1;     // read image, first sync stage
    logic [7:0] img_s2;     // read image, second sync stage
  } acp_link_s;

  // state of the logic on the master clock
  typedef struct packed {
    logic       cs_s1;      // chip select sync stages
    logic       cs_s2;
    logic       rst_s1;     // reset pin sync stages
    logic       rst_s2;
    logic       p0_s1;      // pin level sync stages
    logic       p0_s2;
    logic       p1_s1;
    logic       p1_s2;
    logic       wr_s1;      // write toggle sync stages
    logic       wr_s2;
    logic       wr_s3;      // previous value for edge detect
    logic       dev_rst;    // device reset from the reset pin
    logic       mclk_en;    // master clock output enable
    acp_port_s  port;       // port register
    logic [7:0] img;        // read image of the port register
    logic       p0_o;       // pin drivers
    logic       p0_oe;
    logic       p1_o;
    logic       p1_oe;
    logic       dout_oe;    // serial output enable
    logic       ready_n;    // ready status, active low
    logic       align;      // align request to filter/modulator
  } acp_core_s;
endpackage

/* test/acp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// host side of the serial port: clock idles low, msb first
module acp_host_model (
  // serial lines
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // select; the wait covers the chip select synchroniser
  task automatic sel();
    cs_n_out = 1'b0;
    #300;
  endtask
  // deselect; a partial byte is abandoned here
  task automatic desel();
    #100;
    cs_n_out = 1'b1;
    #300;
  endtask
  // shift n bits; host owns the clock, one 125 ns period a bit
  task automatic shift(input logic [7:0] b, input int n,
                       output logic [7:0] rd);
    int i;
    rd = 8'h00;
    for (i = 0; i < n; i++) begin
      din_out = b[7-i];
      #62.5;
      sclk_out = 1'b1;
      rd = {rd[6:0], dout_in};
      #62.5;
      sclk_out = 1'b0;
    end
    // released line shows the inverse, never the last value
    din_out = ~din_out;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acp_pkg::*;
  // ====
  // stimulus, pin wires and counters
  logic       clk_in, rst_in, reset_n, mclk_en, p0_ext, p1_ext;
  logic       cal_mode, cal_done;
  logic [1:0] unread;
  wire        sclk, cs_n, din, dout, dout_oe, dev_rst, mclk_out;
  wire        p0_o, p0_oe, p1_o, p1_oe, rdy_n, align;
  wire        p0_wire, p1_wire;
  acp_port_s  port_v;
  int         n_errors, n_compared;
  logic [7:0] rdv;
  // the pin level is the device's drive when enabled, else ours
  assign p0_wire = p0_oe ? p0_o : p0_ext;
  assign p1_wire = p1_oe ? p1_o : p1_ext;
  initial clk_in = 1'b0;
  always #25 clk_in = ~clk_in;
  acp_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
                         .dout_in(dout));
  acp_pin_ctrl i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
    .reset_n_in(reset_n), .device_reset_out(dev_rst),
    .mclk_enable_in(mclk_en), .master_clock_out(mclk_out),
    .general_pin_zero_in(p0_wire), .general_pin_zero_out(p0_o),
    .general_pin_zero_oe_out(p0_oe), .general_pin_one_in(p1_wire),
    .general_pin_one_out(p1_o), .general_pin_one_oe_out(p1_oe),
    .channel_unread_in(unread), .cal_mode_in(cal_mode),
    .cal_done_in(cal_done), .ready_n_out(rdy_n),
    .align_or_pin_one_out(align), .port_reg_out(port_v));
  // ====
  // compare and access tasks
  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic clk_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // command then data; split reframes between the two bytes
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data,
                    input logic frame, input logic split);
    logic [7:0] d;
    if (frame) i_host.sel();
    i_host.shift(cmd, 8, d);
    if (split) begin
      i_host.desel();
      i_host.sel();
    end
    i_host.shift(data, 8, d);
    if (frame) i_host.desel();
    clk_n(8);
  endtask
  task automatic rd(input logic [5:0] addr, input logic frame,
                    output logic [7:0] v);
    logic [7:0] d;
    if (frame) i_host.sel();
    i_host.shift({2'b01, addr}, 8, d);
    i_host.shift(8'h00, 8, v);
    chk1("dout_oe", 1'b1, dout_oe);
    if (frame) i_host.desel();
  endtask
  // bounded wait for the device reset to clear
  task automatic wait_rel();
    int i;
    for (i = 0; i < 20 && dev_rst !== 1'b0; i++) clk_n(1);
    chk1("device_reset", 1'b0, dev_rst);
  endtask
  task automatic mclk_chk();
    @(negedge clk_in);
    #1;
    chk1("mclk_low_phase", mclk_en, mclk_out);
    @(posedge clk_in);
    #1;
    chk1("mclk_high_phase", 1'b0, mclk_out);
    @(negedge clk_in);
  endtask
  // ready over unread and calibration combinations
  task automatic rdy_sweep(input logic rf);
    int   i;
    logic e;
    for (i = 0; i < 8; i++) begin
      unread   = i[1:0];
      cal_mode = i[2];
      cal_done = i[0];
      e = cal_mode ? ~cal_done : (rf ? ~&unread : ~|unread);
      clk_n(3);
      chk1("ready_n", e, rdy_n);
    end
    cal_mode = 1'b0;
  endtask
  task automatic stop_test();
    $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ====
  // watchdog, far beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end
  // ====
  // main sequence
  initial begin
    rst_in = 1'b1; reset_n = 1'b1; mclk_en = 1'b1;
    p0_ext = 1'b0; p1_ext = 1'b0; cal_mode = 1'b0; cal_done = 1'b0;
    unread = 2'h0; n_errors = 0; n_compared = 0;
    clk_n(8);
    chk1("device_reset", 1'b1, dev_rst);
    chk8("port_reset", 8'h30, port_v);
    chk1("ready_reset", 1'b1, rdy_n);
    rst_in = 1'b0;
    wait_rel();
    $display("test reset done");
    wr(8'h01, 8'hc0, 1'b1, 1'b1);
    chk8("port", 8'hc0, port_v);
    chk1("p0_oe", 1'b1, p0_oe);
    chk1("p1_oe", 1'b1, p1_oe);
    wr(8'h01, 8'h40, 1'b1, 1'b0);
    chk1("p0_out", 1'b0, p0_o);
    chk1("p1_out", 1'b1, p1_o);
    $display("test pin drive done");
    i_host.shift(8'h01, 8, rdv);
    i_host.shift(8'hff, 8, rdv);
    clk_n(8);
    chk8("port_unselected", 8'h40, port_v);
    wr(8'h81, 8'h81, 1'b1, 1'b0);
    chk8("port_bad_cmd", 8'h40, port_v);
    wr(8'h02, 8'h00, 1'b1, 1'b0);
    chk8("port_other_addr", 8'h40, port_v);
    rd(6'h02, 1'b1, rdv);
    chk8("read_other", 8'h00, rdv);
    i_host.sel();
    i_host.shift(8'hff, 3, rdv);
    i_host.desel();
    wr(8'h01, 8'h30, 1'b1, 1'b0);
    chk8("port_after_partial", 8'h30, port_v);
    $display("test refusals done");
    p0_ext = 1'b1;
    i_host.sel();
    clk_n(4);
    rd(6'h01, 1'b0, rdv);
    chk8("read_port", 8'hb0, rdv);
    wr(8'h01, 8'h38, 1'b0, 1'b0);
    chk8("port_3wire", 8'h38, port_v);
    i_host.desel();
    chk1("dout_oe_off", 1'b0, dout_oe);
    chk1("p0_oe_in", 1'b0, p0_oe);
    rdy_sweep(1'b1);
    $display("test three wire done");
    wr(8'h01, 8'h0f, 1'b1, 1'b0);
    chk8("port_sync", 8'h09, port_v);
    chk1("p1_oe_sync", 1'b0, p1_oe);
    p1_ext = 1'b0;
    clk_n(5);
    chk1("align_low", 1'b1, align);
    p1_ext = 1'b1;
    clk_n(5);
    chk1("align_high", 1'b0, align);
    $display("test align done");
    mclk_chk();
    mclk_en = 1'b0;
    mclk_chk();
    mclk_en = 1'b1;
    unread = 2'h3;
    reset_n = 1'b0;
    clk_n(4);
    chk1("device_reset_pin", 1'b1, dev_rst);
    chk8("port_pin_reset", 8'h30, port_v);
    chk1("ready_pin_reset", 1'b1, rdy_n);
    mclk_chk();
    reset_n = 1'b1;
    wait_rel();
    rdy_sweep(1'b0);
    $display("test reset pin done");
    stop_test();
  end
endmodule
`default_nettype wire
